// >>> hdl/tslsw_data_store.sv
// Data store: three frame banks of 256 bytes, one write and two read ports.
// Assumes callers never address past the third bank.
`timescale 1ns/1ps
`default_nettype none

module tslsw_data_store (
	input  wire logic       clk_i,
	input  wire logic       we_i,
	input  wire logic [9:0] waddr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic [9:0] raddr_a_i,
	output logic      [7:0] rdata_a_o,
	input  wire logic [9:0] raddr_b_i,
	output logic      [7:0] rdata_b_o
);
	logic [7:0] mem [0:767];

	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i; // see [R3]
		end
	end

	assign rdata_a_o = mem[raddr_a_i];
	assign rdata_b_o = mem[raddr_b_i];
endmodule : tslsw_data_store

`default_nettype wire

// >>> hdl/tslsw_lane.sv
// One serial stream: receive shifter and transmit shifter.
// Assumes the strobes come from the frame timing of the top module.
`timescale 1ns/1ps
`default_nettype none

module tslsw_lane (
	input  wire logic       clk_i,
	input  wire logic       reset_n_i,
	input  wire logic       sample_i,
	input  wire logic       rx_bit_i,
	input  wire logic       shift_i,
	input  wire logic       load_i,
	input  wire logic [7:0] load_byte_i,
	output logic      [7:0] rx_byte_o,
	output logic            tx_bit_o
);
	tslsw_pkg::tslsw_lane_t s;
	tslsw_pkg::tslsw_lane_t next_s;

	// Both shifters run most significant bit first.
	always_comb begin
		next_s = s;
		if (sample_i) begin
			next_s.rx = {s.rx[6:0], rx_bit_i}; // see [R3]
		end
		if (load_i) begin
			next_s.tx = load_byte_i; // see [R7]
		end else if (shift_i) begin
			next_s.tx = {s.tx[6:0], 1'b0};
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s <= tslsw_pkg::LANE_RST;
		end else begin
			s <= next_s;
		end
	end

	assign rx_byte_o = s.rx;
	assign tx_bit_o  = s.tx[7];
endmodule : tslsw_lane

`default_nettype wire

// >>> hdl/tslsw_pkg.sv
// Constants, field layouts and state types of the TDM time slot switch.
// Assumes a single 200 MHz system clock and synchronous serial pins.
//
// Function
// [R1] Eight serial inputs and outputs, 32 byte channels each, a 256 by 256 matrix.
// [R2] The system supplies a continuous 4.096 MHz bit clock.
// [R3] Received channels are stored in parallel form in a 256-position data store.
// [R4] A frame counter gives the store write address and restarts on each frame pulse.
// [R5] Each output channel picks variable or constant delay by its own bit.
// [R6] Connection mode sends a data store byte; message mode sends the low entry.
// [R7] Each output byte is fetched in the slot before it is sent.
// [R8] The low entry names source stream and channel; outputs may share a source.
// [R9] A message byte repeats every frame until the processor rewrites it.
// [R10] The high entry holds message, delay, driver enable and control-line bits.
// [R11] A cleared driver enable floats that output for that channel slot only; the code drives the slot anyway while msg_all is set.
// [R12] A low global gate floats every output channel whatever the enables say.
// [R13] Processor store addresses join control register fields with address inputs.
// [R14] Frame pulse polarity is found automatically and picks the timing format.
// [R15] Active-low format: falling edges mark bits, rising edge samples at three quarters.
// [R16] Active-high format: rising edges mark bits, sampling at three quarters.
// [R17] Variable delay depends on channel numbers only and is at least three slots.
// [R18] Variable delay, output zero to two slots after input: next frame, plus 32.
// [R19] Variable delay, output three or more slots after input: the difference.
// [R20] Variable delay, output before input: next frame, 32 minus the difference.
// [R21] The processor writes the connection stores over the eight-bit data port.
// [R22] The control line sends 256 bits per frame taken from the high entries.
// [R23] Constant delay sends a byte of input frame N in output frame N+2.
// [R24] Before a frame pulse is identified, outputs float and counters stay reset.
`default_nettype none

package tslsw_pkg;
	localparam int         STREAMS     = 8;
	// =====================================================================
	// Register port decode.
	localparam logic [5:0] CTRL_MASK   = 6'h23;
	localparam logic [5:0] CTRL_ADDR   = 6'h00;
	localparam logic [5:0] STATUS_ADDR = 6'h01;
	localparam int         MEM_SEL_BIT = 5;
	localparam logic [1:0] MSEL_DATA   = 2'h1;
	localparam logic [1:0] MSEL_LOW    = 2'h2;
	localparam logic [1:0] MSEL_HIGH   = 2'h3;
	// =====================================================================
	// Timing and switching counts.
	localparam logic [3:0] LOCK_RUN    = 4'h8;
	localparam logic [1:0] BANK_LAST   = 2'h2;
	localparam logic [4:0] VAR_MIN_GAP = 5'h03;
	localparam logic [1:0] CONST_LAG   = 2'h2;
	localparam logic [2:0] BIT_LAST    = 3'h7;
	localparam logic [2:0] LANE_LAST   = 3'h7;
	// =====================================================================
	// Types.
	typedef struct packed {
		logic       split;
		logic       msg_all;
		logic       rsvd;
		logic [1:0] msel;
		logic [2:0] stream;
	} tslsw_ctrl_t;

	typedef struct packed {
		logic       const_dly;
		logic       msg;
		logic       aux;
		logic       oe;
		logic [7:0] low;
	} tslsw_cs_t;

	typedef struct packed {
		logic [7:0] rx;
		logic [7:0] tx;
	} tslsw_lane_t;

	typedef enum logic [1:0] {SEQ_IDLE, SEQ_WR, SEQ_FETCH} tslsw_seq_t;

	typedef struct packed {
		logic            bck_q;
		logic            fp_last;
		logic            fp_idle;
		logic            locked;
		logic [3:0]      run;
		logic            synced;
		logic [8:0]      cnt;
		logic [1:0]      wb;
		tslsw_seq_t      seq;
		logic [2:0]      step;
		logic [4:0]      ch;
		logic [1:0]      fo;
		logic [7:0][7:0] nxt_byte;
		logic [7:0]      nxt_en;
		logic [7:0]      cur_en;
		logic [7:0]      oe_n;
		logic            aux;
		tslsw_ctrl_t     ctrl;
		logic [7:0]      rdata;
	} tslsw_state_t;

	localparam tslsw_lane_t  LANE_RST  = 16'h0000;
	localparam tslsw_state_t STATE_RST = '{oe_n: 8'hFF, seq: SEQ_IDLE, default: '0};
endpackage : tslsw_pkg

`default_nettype wire

// >>> hdl/tslsw_top.sv
// Top of the TDM time slot switch: frame timing, switching path, processor port.
// Assumes bit clock, frame pulse, serial inputs and the register port are synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none

module tslsw_top (
	input  wire logic       clk_i,
	input  wire logic       reset_n_i,
	input  wire logic       bit_clock_in_i,
	input  wire logic       frame_pulse_in_i,
	input  wire logic [7:0] serial_in_streams_i,
	input  wire logic       global_output_gate_i,
	output logic      [7:0] serial_out_streams_o,
	output logic      [7:0] serial_out_oe_n_o,
	output logic            aux_control_line_o,
	input  wire logic [5:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	output logic      [7:0] reg_rdata_o
);
	// =====================================================================
	// Declarations.
	tslsw_pkg::tslsw_state_t s;
	tslsw_pkg::tslsw_state_t next_s;
	tslsw_pkg::tslsw_cs_t    cs_mem [0:255];
	tslsw_pkg::tslsw_cs_t    sw_ent;
	tslsw_pkg::tslsw_cs_t    cpu_ent;
	tslsw_pkg::tslsw_cs_t    aux_ent;

	logic [7:0][7:0] rx_bytes;
	logic            rise;
	logic            fall;
	logic            gci;
	logic            bnd_edge;
	logic            smp_edge;
	logic            fp_act;
	logic            samp;
	logic            last_samp;
	logic            bnd;
	logic            slot_go;
	logic [4:0]      src_ch;
	logic [4:0]      gap;
	logic [1:0]      lag;
	logic            use_msg;
	logic            dm_we;
	logic [9:0]      dm_waddr;
	logic [7:0]      dm_wdata;
	logic [9:0]      dm_raddr_a;
	logic [9:0]      dm_raddr_b;
	logic [7:0]      dm_rdata_a;
	logic [7:0]      dm_rdata_b;
	logic            cpu_ctrl;
	logic            cpu_status;
	logic            cpu_mem;
	logic [7:0]      cpu_idx;
	logic            cs_we_low;
	logic            cs_we_high;

	// =====================================================================
	// Bank arithmetic over three frame banks.
	function automatic logic [1:0] bank_next(input logic [1:0] b);
		bank_next = (b == tslsw_pkg::BANK_LAST) ? 2'h0 : 2'(b + 2'h1);
	endfunction : bank_next

	function automatic logic [1:0] bank_back(input logic [1:0] b, input logic [1:0] k);
		logic [2:0] t;
		t = 3'({1'b0, b} + 3'h3 - {1'b0, k});
		bank_back = (t >= 3'h3) ? 2'(t - 3'h3) : t[1:0];
	endfunction : bank_back

	// =====================================================================
	// Stream shifters and data store.
	for (genvar i = 0; i < tslsw_pkg::STREAMS; i++) begin : g_lane // see [R1]
		tslsw_lane u_lane (
			.clk_i       (clk_i),
			.reset_n_i   (reset_n_i),
			.sample_i    (samp),
			.rx_bit_i    (serial_in_streams_i[i]),
			.shift_i     (bnd),
			.load_i      (slot_go),
			.load_byte_i (s.nxt_byte[i]),
			.rx_byte_o   (rx_bytes[i]),
			.tx_bit_o    (serial_out_streams_o[i])
		);
	end

	tslsw_data_store u_store (
		.clk_i     (clk_i),
		.we_i      (dm_we),
		.waddr_i   (dm_waddr),
		.wdata_i   (dm_wdata),
		.raddr_a_i (dm_raddr_a),
		.rdata_a_o (dm_rdata_a),
		.raddr_b_i (dm_raddr_b),
		.rdata_b_o (dm_rdata_b)
	);

	// =====================================================================
	// Next-state logic.
	always_comb begin
		next_s       = s;
		next_s.bck_q = bit_clock_in_i;
		rise         = bit_clock_in_i & ~s.bck_q;
		fall         = ~bit_clock_in_i & s.bck_q;

		// An idle-low frame pulse means the active-high format.
		gci      = ~s.fp_idle;
		bnd_edge = gci ? rise : fall; // see [R15] [R16]
		smp_edge = gci ? fall : rise; // see [R15] [R16]
		fp_act   = s.locked & (frame_pulse_in_i != s.fp_idle);

		// The level that holds for a run of bit clocks is the idle level.
		if (rise) begin
			if (frame_pulse_in_i == s.fp_last) begin
				if (s.run != tslsw_pkg::LOCK_RUN) begin
					next_s.run = 4'(s.run + 4'h1);
				end else begin
					next_s.fp_idle = frame_pulse_in_i; // see [R14]
					next_s.locked  = 1'b1;
				end
			end else begin
				next_s.run     = 4'h0;
				next_s.fp_last = frame_pulse_in_i;
			end
		end

		// The counter waits at zero until the first identified frame pulse.
		if (bnd_edge) begin
			if (fp_act) begin
				next_s.cnt    = 9'h000; // see [R4] [R24]
				next_s.synced = 1'b1;
				if (s.synced) begin
					next_s.wb = bank_next(s.wb);
				end
			end else if (s.synced) begin
				next_s.cnt = 9'(s.cnt + 9'h001); // see [R4]
			end
		end

		samp      = smp_edge & s.synced & s.cnt[0];
		last_samp = samp & (s.cnt[3:1] == tslsw_pkg::BIT_LAST);
		bnd       = bnd_edge & next_s.synced & ~next_s.cnt[0];
		slot_go   = bnd & (next_s.cnt[3:1] == 3'h0);

		// Switching path lookup for the entry under fetch.
		sw_ent  = cs_mem[{s.step, s.ch}];
		src_ch  = sw_ent.low[4:0];
		gap     = 5'(s.ch - src_ch);
		use_msg = s.ctrl.msg_all | sw_ent.msg;
		if (sw_ent.const_dly) begin
			lag = tslsw_pkg::CONST_LAG; // see [R5] [R23]
		end else begin
			// Modular gap: below three slots waits one more frame.
			lag = 2'({1'b0, s.ch < src_ch} + {1'b0, gap < tslsw_pkg::VAR_MIN_GAP}); // see [R17] [R18] [R19] [R20]
		end
		dm_raddr_a = {bank_back(s.fo, lag), sw_ent.low}; // see [R8]
		dm_we      = 1'b0;
		dm_waddr   = {s.wb, s.step, s.ch};
		dm_wdata   = rx_bytes[s.step];

		// =================================================================
		// Store sequencer: eight writes after a byte, eight fetches per slot.
		case (s.seq)
			tslsw_pkg::SEQ_WR: begin
				dm_we       = 1'b1; // see [R3]
				next_s.step = 3'(s.step + 3'h1);
				if (s.step == tslsw_pkg::LANE_LAST) begin
					next_s.seq = tslsw_pkg::SEQ_IDLE;
				end
			end
			tslsw_pkg::SEQ_FETCH: begin
				next_s.nxt_byte[s.step] = use_msg ? sw_ent.low : dm_rdata_a; // see [R6] [R9]
				next_s.nxt_en[s.step]   = s.ctrl.msg_all | sw_ent.oe; // see [R10]
				next_s.step             = 3'(s.step + 3'h1);
				if (s.step == tslsw_pkg::LANE_LAST) begin
					next_s.seq = tslsw_pkg::SEQ_IDLE;
				end
			end
			default: begin
				next_s.seq = tslsw_pkg::SEQ_IDLE;
			end
		endcase

		if (last_samp) begin
			next_s.seq  = tslsw_pkg::SEQ_WR;
			next_s.step = 3'h0;
			next_s.ch   = s.cnt[8:4];
		end else if (slot_go) begin
			// Fetch for the next channel during the slot before it.
			next_s.seq  = tslsw_pkg::SEQ_FETCH; // see [R7]
			next_s.step = 3'h0;
			next_s.ch   = 5'(next_s.cnt[8:4] + 5'h01);
			next_s.fo   = (next_s.ch == 5'h00) ? bank_next(next_s.wb) : next_s.wb;
		end

		// =================================================================
		// Output drivers and control line.
		if (slot_go) begin
			next_s.cur_en = s.nxt_en; // see [R11]
		end
		for (int i = 0; i < tslsw_pkg::STREAMS; i++) begin
			next_s.oe_n[i] = ~(next_s.synced & global_output_gate_i & next_s.cur_en[i]); // see [R11] [R12] [R24]
		end
		aux_ent = cs_mem[{next_s.cnt[3:1], 5'(next_s.cnt[8:4] + 5'h01)}];
		if (bnd) begin
			next_s.aux = aux_ent.aux; // see [R22]
		end
		if (!next_s.synced) begin
			next_s.aux = 1'b0;
		end

		// =================================================================
		// Processor port.
		cpu_ctrl   = (reg_addr_i & tslsw_pkg::CTRL_MASK) == tslsw_pkg::CTRL_ADDR;
		cpu_status = reg_addr_i == tslsw_pkg::STATUS_ADDR;
		cpu_mem    = reg_addr_i[tslsw_pkg::MEM_SEL_BIT];
		cpu_idx    = {s.ctrl.stream, reg_addr_i[4:0]}; // see [R13]
		cpu_ent    = cs_mem[cpu_idx];
		dm_raddr_b = {bank_back(s.wb, 2'h1), cpu_idx};
		cs_we_low  = reg_wr_i & cpu_mem & (s.ctrl.split | (s.ctrl.msel == tslsw_pkg::MSEL_LOW));
		cs_we_high = reg_wr_i & cpu_mem & ~s.ctrl.split & (s.ctrl.msel == tslsw_pkg::MSEL_HIGH);
		if (reg_wr_i & cpu_ctrl) begin
			next_s.ctrl = tslsw_pkg::tslsw_ctrl_t'(reg_wdata_i);
		end
		next_s.rdata = 8'h00;
		if (reg_rd_i) begin
			if (cpu_ctrl) begin
				next_s.rdata = s.ctrl;
			end else if (cpu_status) begin
				next_s.rdata = {s.locked, gci, s.synced, 3'h0, s.wb};
			end else if (cpu_mem) begin
				if (s.ctrl.split || (s.ctrl.msel == tslsw_pkg::MSEL_DATA)) begin
					next_s.rdata = dm_rdata_b;
				end else if (s.ctrl.msel == tslsw_pkg::MSEL_LOW) begin
					next_s.rdata = cpu_ent.low;
				end else if (s.ctrl.msel == tslsw_pkg::MSEL_HIGH) begin
					next_s.rdata = {4'h0, cpu_ent[11:8]};
				end
			end
		end
	end

	// =====================================================================
	// State register.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s <= tslsw_pkg::STATE_RST;
		end else begin
			s <= next_s;
		end
	end

	// =====================================================================
	// Connection store, written only by the processor.
	always_ff @(posedge clk_i) begin
		if (cs_we_low) begin
			cs_mem[cpu_idx].low <= reg_wdata_i; // see [R21]
		end
		if (cs_we_high) begin
			cs_mem[cpu_idx][11:8] <= reg_wdata_i[3:0]; // see [R10] [R21]
		end
	end

	assign serial_out_oe_n_o  = s.oe_n;
	assign aux_control_line_o = s.aux;
	assign reg_rdata_o        = s.rdata;
endmodule : tslsw_top

`default_nettype wire

// >>> sim/tslsw_assertions.sv
// Checker for tslsw_top: register port answers and serial pin timing.
// Assumes it is bound to tslsw_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module tslsw_assertions (
	input wire logic       clk_i,
	input wire logic       reset_n_i,
	input wire logic       bit_clock_in_i,
	input wire logic       global_output_gate_i,
	input wire logic [7:0] serial_out_streams_o,
	input wire logic [7:0] serial_out_oe_n_o,
	input wire logic [5:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic       reg_wr_i,
	input wire logic       reg_rd_i,
	input wire logic [7:0] reg_rdata_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);

	// ====================
	// Shadow of the last control register write.
	logic [7:0] ctrl_copy;

	always_ff @(posedge clk_i or negedge reset_n_i)
		if (!reset_n_i)
			ctrl_copy <= 8'h00;
		else if (reg_wr_i && (reg_addr_i & 6'h23) == 6'h00)
			ctrl_copy <= reg_wdata_i;

	// ====================
	// Properties.
	sequence s_gate_low;
		!global_output_gate_i [*3];
	endsequence
	sequence s_ctrl_rd;
		reg_rd_i && (reg_addr_i & 6'h23) == 6'h00;
	endsequence
	property p_float_at_start;
		$rose(reset_n_i) |-> (serial_out_oe_n_o == 8'hFF) [*8];
	endproperty
	property p_gate_floats;
		s_gate_low |-> serial_out_oe_n_o == 8'hFF;
	endproperty
	property p_rdata_idle;
		!reg_rd_i |=> reg_rdata_o == 8'h00;
	endproperty
	property p_ctrl_read;
		s_ctrl_rd |=> reg_rdata_o == ctrl_copy;
	endproperty
	property p_unmapped_read;
		reg_rd_i && reg_addr_i == 6'h02 |=> reg_rdata_o == 8'h00;
	endproperty
	property p_data_hold;
		$changed(serial_out_streams_o) |=> $stable(serial_out_streams_o) [*8];
	endproperty
	property p_data_on_edge;
		$changed(serial_out_streams_o) |-> $past(bit_clock_in_i, 1) != $past(bit_clock_in_i, 2)
			|| $past(bit_clock_in_i, 2) != $past(bit_clock_in_i, 3);
	endproperty
	property p_oe_slot;
		$changed(serial_out_oe_n_o) && global_output_gate_i
			|=> ($stable(serial_out_oe_n_o) || !global_output_gate_i) [*8];
	endproperty

	a_float_at_start: assert property (p_float_at_start) else $error("outputs driven after reset");
	a_gate_floats: assert property (p_gate_floats) else $error("outputs driven with gate low");
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data without a read");
	a_ctrl_read: assert property (p_ctrl_read) else $error("control read differs from write");
	a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");
	a_data_hold: assert property (p_data_hold) else $error("output bit too short");
	a_data_on_edge: assert property (p_data_on_edge) else $error("output bit off the clock edge");
	a_oe_slot: assert property (p_oe_slot) else $error("enable changed inside a slot");
endmodule : tslsw_assertions

`default_nettype wire

// >>> sim/tslsw_line_model.sv
// Line side model: bit clock, active-low frame pulse and eight counted input streams.
// Assumes clk_i is the bench clock; HALF is the bit clock half period in clk_i cycles.
`timescale 1ns/1ps
`default_nettype none

module tslsw_line_model #(
	parameter int HALF = 5
) (
	input  wire logic       clk_i,
	output logic            bit_clock_o,
	output logic            frame_pulse_o,
	output logic      [7:0] serial_o,
	output logic            smp_o,
	output logic      [4:0] ch_o,
	output logic      [7:0] fr_o
);
	logic [2:0] bit_n;
	logic [7:0] src;

	task automatic half(input logic lvl);
		@(posedge clk_i);
		smp_o <= 1'b0;
		repeat (HALF - 1) @(posedge clk_i);
		bit_clock_o <= lvl;
	endtask : half

	// Each input byte carries its frame, stream and channel so any slip shows.
	initial begin
		bit_clock_o = 1'b1;
		frame_pulse_o = 1'b1;
		serial_o = 8'h00;
		smp_o = 1'b0;
		ch_o = 5'h1F;
		bit_n = 3'h0;
		fr_o = 8'hFF;
		forever begin
			half(1'b0);
			if (bit_n == 3'h0) begin
				if (ch_o == 5'h1F)
					fr_o = fr_o + 8'h01;
				ch_o = ch_o + 5'h01;
			end
			bit_n = bit_n - 3'h1;
			for (int s = 0; s < 8; s++) begin
				src = {fr_o[2:0] ^ 3'(s), ch_o};
				serial_o[s] <= src[bit_n];
			end
			half(1'b1);
			frame_pulse_o <= 1'b1;
			half(1'b0);
			half(1'b1);
			smp_o <= 1'b1;
			if (ch_o == 5'h1F && bit_n == 3'h0)
				frame_pulse_o <= 1'b0;
		end
	end
endmodule : tslsw_line_model

`default_nettype wire

// >>> sim/tslsw_tb_top.sv
// Bench for tslsw_top: registers, both delay modes, gating, message mode and control line.
// Assumes tslsw_line_model drives the serial side and tslsw_assertions is bound below.
`timescale 1ns/1ps
`default_nettype none

module tslsw_tb_top;
	logic       clk_i;
	logic       reset_n_i;
	logic       bck;
	logic       fp;
	logic [7:0] sin;
	logic       gate;
	logic [7:0] sout;
	logic [7:0] oe_n;
	logic       aux;
	logic [5:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;
	logic       smp;
	logic [4:0] ch;
	logic [7:0] fr;
	logic [7:0] got [8][32];
	logic [7:0] gz [8][32];
	logic [7:0] gaux [32];
	logic [7:0] lo [8][32];
	logic [3:0] hi [8][32];
	int         n_errors;
	int         compares;

	// The bit clock runs faster than on a real line to keep frames short.
	tslsw_line_model #(.HALF(5)) u_line (.clk_i(clk_i), .bit_clock_o(bck), .frame_pulse_o(fp),
		.serial_o(sin), .smp_o(smp), .ch_o(ch), .fr_o(fr));
	tslsw_top dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .bit_clock_in_i(bck), .frame_pulse_in_i(fp),
		.serial_in_streams_i(sin), .global_output_gate_i(gate), .serial_out_streams_o(sout),
		.serial_out_oe_n_o(oe_n), .aux_control_line_o(aux), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata));

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	always @(posedge clk_i)
		if (smp) begin
			for (int s = 0; s < 8; s++) begin
				got[s][ch] <= {got[s][ch][6:0], sout[s]};
				gz[s][ch] <= {gz[s][ch][6:0], oe_n[s]};
			end
			gaux[ch] <= {gaux[ch][6:0], aux};
		end

	task automatic cmp(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmp

	task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
		@(posedge clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask : rd_reg

	function automatic logic [7:0] exp_out(input int s, input int m, input int f);
		int d;
		d = (m - int'(lo[s][m][4:0])) & 31;
		if (hi[s][m][3])
			f = f - 2;
		else
			f = (f * 32 + m - (d >= 3 ? d : d + 32)) >> 5;
		return hi[s][m][2] ? lo[s][m] : {3'(f) ^ lo[s][m][7:5], lo[s][m][4:0]};
	endfunction : exp_out

	function automatic logic [7:0] aux_exp(input int c);
		logic [7:0] v;
		for (int k = 0; k < 8; k++)
			v[7 - k] = hi[k][(c + 1) % 32][1];
		return v;
	endfunction : aux_exp

	task automatic t_regs;
		logic [7:0] d;
		cmp(oe_n, 8'hFF);
		wr_reg(6'h00, 8'h2B);
		rd_reg(6'h00, d);
		cmp(d, 8'h2B);
		rd_reg(6'h02, d);
		cmp(d, 8'h00);
	endtask : t_regs

	// Streams 2k and 2k+1 share a source, odd streams use constant delay, stream 6 sends messages.
	task automatic t_program;
		logic [7:0] d;
		for (int s = 0; s < 8; s++) begin
			wr_reg(6'h00, {3'h0, 2'h2, 3'(s)});
			for (int m = 0; m < 32; m++) begin
				lo[s][m] = (s == 6) ? (8'h5A ^ 8'(m)) : {3'(s >> 1), 5'(7 * m)};
				hi[s][m] = {1'(s), (s == 6), ((m + s) % 3 == 0), !(s == 2 && m == 5)};
				wr_reg({1'b1, 5'(m)}, lo[s][m]);
			end
			wr_reg(6'h00, {3'h0, 2'h3, 3'(s)});
			for (int m = 0; m < 32; m++)
				wr_reg({1'b1, 5'(m)}, {4'h0, hi[s][m]});
		end
		rd_reg(6'h25, d);
		cmp(d, {4'h0, hi[7][5]});
	endtask : t_program

	task automatic t_frame(input logic [7:0] f, input logic gated);
		wait (fr == f + 8'h01);
		for (int s = 0; s < 8; s++)
			for (int m = 0; m < 32; m++) begin
				cmp(gz[s][m], (gated || !hi[s][m][0]) ? 8'hFF : 8'h00);
				if (!gated && hi[s][m][0])
					cmp(got[s][m], exp_out(s, m, f));
			end
		for (int c = 0; c < 32; c++)
			cmp(gaux[c], aux_exp(c));
	endtask : t_frame

	task automatic t_gate;
		gate <= 1'b0;
		t_frame(8'h07, 1'b1);
	endtask : t_gate

	task automatic t_message;
		wait (fr == 8'h08);
		repeat (40) @(posedge clk_i);
		gate <= 1'b1;
		wr_reg(6'h00, {3'h0, 2'h2, 3'h6});
		lo[6][3] = 8'hC3;
		wr_reg(6'h23, 8'hC3);
		t_frame(8'h09, 1'b0);
	endtask : t_message

	task automatic t_status;
		logic [7:0] d;
		rd_reg(6'h01, d);
		cmp(d & 8'hE0, 8'hA0);
	endtask : t_status

	task automatic close_out;
		$display("errors=%0d compares=%0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out

	initial begin
		reset_n_i = 1'b0;
		gate = 1'b1;
		addr = 6'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		n_errors = 0;
		compares = 0;
		repeat (20) @(posedge clk_i);
		reset_n_i <= 1'b1;
		t_regs();
		t_program();
		t_frame(8'h05, 1'b0);
		t_frame(8'h06, 1'b0);
		t_gate();
		t_message();
		t_status();
		close_out();
	end

	initial begin
		repeat (80000) @(posedge clk_i);
		n_errors++;
		close_out();
	end
endmodule : tslsw_tb_top

bind tslsw_top tslsw_assertions u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .bit_clock_in_i(bit_clock_in_i),
	.global_output_gate_i(global_output_gate_i), .serial_out_streams_o(serial_out_streams_o),
	.serial_out_oe_n_o(serial_out_oe_n_o), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
	.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));

`default_nettype wire
